/* common/osdw2_consts.vh */
// register map, reset values and geometry constants of the second osd window
`ifndef OSDW2_CONSTS_VH
`define OSDW2_CONSTS_VH
// register byte addresses
`define OSDW2_ADDR_HSTART     16'h8418
`define OSDW2_ADDR_VSTART     16'h8419
`define OSDW2_ADDR_RAMLOC_LO  16'h841A
`define OSDW2_ADDR_RAMLOC_HI  16'h841B
`define OSDW2_ADDR_MASK_B0    16'h841C
`define OSDW2_ADDR_MASK_B1    16'h841D
`define OSDW2_ADDR_MASK_B2    16'h841E
`define OSDW2_ADDR_MASK_B3    16'h841F
// reset values
`define OSDW2_RST_HSTART      8'h00
`define OSDW2_RST_VSTART      8'h00
`define OSDW2_RST_RAMLOC      9'h000
`define OSDW2_RST_MASK        32'h00000000
// field positions
`define OSDW2_RAMLOC_MSB      8
`define OSDW2_HS_SHIFT        2
`define OSDW2_VS_SHIFT        1
// horizontal geometry in osd pixels
`define OSDW2_HS_OFFSET       11'h01E
`define OSDW2_H_EARLIEST      11'h02A
// column widths in osd pixels and number of maskable columns
`define OSDW2_COL_NORMAL      5'h0C
`define OSDW2_COL_DOUBLE      5'h18
`define OSDW2_MASK_COLS       7'h20
`endif

/* design/osdw2_col_gen.v */
// column walker: column index, font pixel index and pixel doubling per column
`timescale 1ns/1ps
`default_nettype none
`include "osdw2_consts.vh"
module osdw2_col_gen (
  input  wire        ref_clk,
  input  wire        reset_n,
  input  wire        start,        // first window pixel of the line
  input  wire        run,          // window pixel time on this line
  input  wire [31:0] mask,         // double width mask
  input  wire [6:0]  num_cols,     // characters on the row
  output wire [6:0]  col,          // current column
  output wire [3:0]  font_x,       // font pixel 0..11
  output wire        col_first,    // first pixel of a column
  output wire        active        // a column is being drawn
);
  reg  [6:0] col_q;                // column counter
  reg  [6:0] col_d;
  reg  [4:0] px_q;                 // pixel within column
  reg  [4:0] px_d;
  reg        busy_q;               // drawing in progress
  reg        busy_d;
  wire       dbl;                  // current column doubled
  wire [4:0] width;                // current column width

  // only the first 32 columns can be doubled
  assign dbl    = (col_q < `OSDW2_MASK_COLS) ? mask[col_q[4:0]] : 1'b0;
  assign width  = dbl ? `OSDW2_COL_DOUBLE : `OSDW2_COL_NORMAL;
  // doubled column shows each font pixel on two adjacent positions
  assign font_x = dbl ? px_q[4:1] : px_q[3:0];
  assign col_first = busy_q && (px_q == 5'h00);
  assign col    = col_q;
  assign active = busy_q;

  // next column / pixel state
  always @* begin
    col_d  = col_q;
    px_d   = px_q;
    busy_d = busy_q;
    if (start) begin
      // restart at column zero each line
      col_d  = 7'h00;
      px_d   = 5'h00;
      busy_d = (num_cols != 7'h00);
    end else if (!run) begin
      busy_d = 1'b0;
    end else if (busy_q) begin
      if (px_q == width - 5'h01) begin
        px_d = 5'h00;
        col_d = col_q + 7'h01;
        // last column finished
        if (col_q + 7'h01 == num_cols) begin
          busy_d = 1'b0;
        end
      end else begin
        px_d = px_q + 5'h01;
      end
    end
  end

  // state registers
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      col_q  <= 7'h00;
      px_q   <= 5'h00;
      busy_q <= 1'b0;
    end else begin
      col_q  <= col_d;
      px_q   <= px_d;
      busy_q <= busy_d;
    end
  end
endmodule
`default_nettype wire

/* design/osdw2_geometry.v */
// second osd window placement, page ram fetch and column geometry
// Contract
// - start pixel is four times start plus thirty
// - earliest drawn start is pixel forty-two
// - top edge is twice vertical start lines
// - compensated character line counts as one line
// - fetch begins at nine-bit ram start location
// - first word is row control code
// - mask bit n sets column n width
// - clear means twelve, set means twenty-four
// - doubled column repeats each font pixel
// - columns beyond thirty-two always normal width
// - window shown independently via own enable
`timescale 1ns/1ps
`default_nettype none
`include "osdw2_consts.vh"
module osdw2_geometry #(
  parameter RAM_AW = 9,            // page ram address width
  parameter RAM_DW = 16            // page ram word width
) (
  input  wire              ref_clk,
  input  wire              reset_n,
  input  wire              reg_wr,            // register write strobe
  input  wire              reg_rd,            // register read strobe
  input  wire [15:0]       reg_addr,          // register byte address
  input  wire [7:0]        reg_wdata,         // write byte
  output reg  [7:0]        reg_rdata,         // read byte
  output reg               reg_rd_valid,      // read answer pulse
  input  wire              win2_enable,       // window shown
  input  wire              hflyback,          // line start pulse
  input  wire              vflyback,          // frame start pulse
  input  wire              char_line_tick,    // compensated line done
  input  wire [9:0]        win2_height_lines, // window height in lines
  input  wire [4:0]        win2_row_lines,    // lines per character row
  input  wire [6:0]        win2_chars_per_row,// characters per row
  input  wire [RAM_DW-1:0] ram_rd_data,       // page ram word, one cycle late
  output reg               ram_rd_en,         // page ram read pulse
  output reg  [RAM_AW-1:0] ram_rd_addr,       // page ram address
  output reg  [RAM_DW-1:0] row_control_code,  // captured row control word
  output reg               row_ctrl_valid,    // row control captured pulse
  output reg               win2_pixel_on,     // window pixel time
  output reg  [6:0]        win2_col,          // column being drawn
  output reg  [3:0]        win2_font_x,       // font pixel column
  output reg  [4:0]        win2_font_line     // line within row
);
  // software registers
  reg  [7:0]        win2_horizontal_start_q;
  reg  [7:0]        win2_vertical_start_q;
  reg  [8:0]        win2_ram_start_location_q;
  reg  [31:0]       win2_column_double_width_mask_q;
  // raster tracking
  reg  [10:0]       h_cnt_q;        // osd pixels since flyback
  reg  [9:0]        v_cnt_q;        // compensated lines since frame start
  reg  [4:0]        row_line_q;     // line within current row
  reg  [RAM_AW-1:0] row_base_q;     // address of current row control word
  reg               ctrl_pend_q;    // row control read in flight
  reg               ctrl_wait_q;    // row control word now on the ram bus
  wire [10:0]       h_start;
  wire [9:0]        v_top;
  wire              in_v;
  wire              h_go;
  wire              h_run;
  wire [6:0]        cg_col;
  wire [3:0]        cg_font_x;
  wire              cg_first;
  wire              cg_active;
  wire [RAM_AW-1:0] char_addr;

  // window start pixel, held off until the pipeline can draw
  function [10:0] start_pixel;
    input [7:0] hs;
    reg   [10:0] raw;
    begin
      raw = {1'b0, hs, 2'b00} + `OSDW2_HS_OFFSET;
      // values of two or less would start before the pipeline is ready
      start_pixel = (raw < `OSDW2_H_EARLIEST) ? `OSDW2_H_EARLIEST : raw;
    end
  endfunction

  assign h_start = start_pixel(win2_horizontal_start_q);
  assign v_top   = {1'b0, win2_vertical_start_q, 1'b0};
  // the top plus height is expected to stay within active video
  assign in_v    = win2_enable && (v_cnt_q >= v_top) &&
                   (v_cnt_q < v_top + win2_height_lines);
  assign h_go    = in_v && (h_cnt_q == h_start);
  assign h_run   = in_v && (h_cnt_q >= h_start);
  // characters follow the row control word
  assign char_addr = row_base_q + {{(RAM_AW-7){1'b0}}, cg_col} + 1'b1;

  // register writes; only the nine address bits are kept
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      win2_horizontal_start_q         <= `OSDW2_RST_HSTART;
      win2_vertical_start_q           <= `OSDW2_RST_VSTART;
      win2_ram_start_location_q       <= `OSDW2_RST_RAMLOC;
      win2_column_double_width_mask_q <= `OSDW2_RST_MASK;
    end else if (reg_wr) begin
      case (reg_addr)
        `OSDW2_ADDR_HSTART:    win2_horizontal_start_q <= reg_wdata;
        `OSDW2_ADDR_VSTART:    win2_vertical_start_q <= reg_wdata;
        `OSDW2_ADDR_RAMLOC_LO: win2_ram_start_location_q[7:0] <= reg_wdata;
        // upper byte: bit 8 only, the rest is dropped
        `OSDW2_ADDR_RAMLOC_HI: win2_ram_start_location_q[`OSDW2_RAMLOC_MSB] <= reg_wdata[0];
        `OSDW2_ADDR_MASK_B0:   win2_column_double_width_mask_q[7:0] <= reg_wdata;
        `OSDW2_ADDR_MASK_B1:   win2_column_double_width_mask_q[15:8] <= reg_wdata;
        `OSDW2_ADDR_MASK_B2:   win2_column_double_width_mask_q[23:16] <= reg_wdata;
        `OSDW2_ADDR_MASK_B3:   win2_column_double_width_mask_q[31:24] <= reg_wdata;
        default: ;           // other addresses belong to other blocks
      endcase
    end
  end

  // register reads, answered one cycle after the strobe
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata    <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `OSDW2_ADDR_HSTART:    reg_rdata <= win2_horizontal_start_q;
          `OSDW2_ADDR_VSTART:    reg_rdata <= win2_vertical_start_q;
          `OSDW2_ADDR_RAMLOC_LO: reg_rdata <= win2_ram_start_location_q[7:0];
          `OSDW2_ADDR_RAMLOC_HI: reg_rdata <= {7'h00, win2_ram_start_location_q[8]};
          `OSDW2_ADDR_MASK_B0:   reg_rdata <= win2_column_double_width_mask_q[7:0];
          `OSDW2_ADDR_MASK_B1:   reg_rdata <= win2_column_double_width_mask_q[15:8];
          `OSDW2_ADDR_MASK_B2:   reg_rdata <= win2_column_double_width_mask_q[23:16];
          `OSDW2_ADDR_MASK_B3:   reg_rdata <= win2_column_double_width_mask_q[31:24];
          default:               reg_rdata <= 8'h00; // unmapped reads zero
        endcase
      end
    end
  end

  // horizontal pixel counter, saturates on long lines
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      h_cnt_q <= 11'h000;
    end else if (hflyback) begin
      h_cnt_q <= 11'h000;
    end else if (h_cnt_q != 11'h7FF) begin
      h_cnt_q <= h_cnt_q + 11'h001;
    end
  end

  // vertical count in compensated lines; scan lines between ticks repeat the line
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      v_cnt_q    <= 10'h000;
      row_line_q <= 5'h00;
      row_base_q <= {RAM_AW{1'b0}};
    end else if (vflyback) begin
      v_cnt_q    <= 10'h000;
      row_line_q <= 5'h00;
      row_base_q <= win2_ram_start_location_q[RAM_AW-1:0];
    end else if (char_line_tick) begin
      if (v_cnt_q != 10'h3FF) begin
        v_cnt_q <= v_cnt_q + 10'h001;
      end
      // rows only advance while inside the window
      if (in_v) begin
        if (row_line_q + 5'h01 >= win2_row_lines) begin
          row_line_q <= 5'h00;
          row_base_q <= row_base_q + {{(RAM_AW-7){1'b0}}, win2_chars_per_row} + 1'b1;
        end else begin
          row_line_q <= row_line_q + 5'h01;
        end
      end
    end
  end

  // column walker
  osdw2_col_gen u_col_gen (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .start     (h_go),
    .run       (h_run),
    .mask      (win2_column_double_width_mask_q),
    .num_cols  (win2_chars_per_row),
    .col       (cg_col),
    .font_x    (cg_font_x),
    .col_first (cg_first),
    .active    (cg_active)
  );

  // page ram fetch: row control at flyback, then one word per column
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ram_rd_en        <= 1'b0;
      ram_rd_addr      <= {RAM_AW{1'b0}};
      ctrl_pend_q      <= 1'b0;
      ctrl_wait_q      <= 1'b0;
      row_control_code <= {RAM_DW{1'b0}};
      row_ctrl_valid   <= 1'b0;
    end else begin
      ram_rd_en      <= 1'b0;
      row_ctrl_valid <= 1'b0;
      ctrl_pend_q    <= 1'b0;
      ctrl_wait_q    <= ctrl_pend_q;
      if (hflyback && in_v) begin
        // row control word never reaches the character path
        ram_rd_en   <= 1'b1;
        ram_rd_addr <= row_base_q;
        ctrl_pend_q <= 1'b1;
      end else if (cg_first) begin
        ram_rd_en   <= 1'b1;
        ram_rd_addr <= char_addr;
      end
      // data arrives the cycle after the pulse; taking it one edge early
      // would latch whatever the ram bus held before the read
      if (ctrl_wait_q) begin
        row_control_code <= ram_rd_data;
        row_ctrl_valid   <= 1'b1;
      end
    end
  end

  // pixel outputs, registered so they line up with the fetch pulse
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      win2_pixel_on  <= 1'b0;
      win2_col       <= 7'h00;
      win2_font_x    <= 4'h0;
      win2_font_line <= 5'h00;
    end else begin
      win2_pixel_on  <= cg_active && h_run;
      win2_col       <= cg_col;
      win2_font_x    <= cg_font_x;
      win2_font_line <= row_line_q;
    end
  end
endmodule
`default_nettype wire

/* tb/osdw2_geometry_asserts.sv */
// concurrent checks on the ports of the second osd window block
`timescale 1ns/1ps
`default_nettype none
module osdw2_geometry_asserts (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rd_valid,
  input wire logic        hflyback,
  input wire logic        ram_rd_en,
  input wire logic        row_ctrl_valid,
  input wire logic        win2_pixel_on,
  input wire logic [6:0]  win2_col,
  input wire logic [3:0]  win2_font_x
);
  logic [7:0]  hs_q;                                           // shadow start byte
  logic [10:0] h_q;                                            // cycles since flyback
  wire  [10:0] raw_px = {1'b0, hs_q, 2'b00} + 11'h01E;         // four per step plus thirty
  wire  [10:0] start_px = (raw_px < 11'h02A) ? 11'h02A : raw_px; // pipeline floor
  // shadow and line counter; saturates so long blank spans never wrap
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hs_q <= 8'h00;
      h_q  <= 11'h000;
    end else begin
      if (reg_wr && reg_addr == 16'h8418) hs_q <= reg_wdata;
      if (hflyback) h_q <= 11'h000;
      else if (h_q != 11'h7FF) h_q <= h_q + 11'h001;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // a read is a strobe then one answer pulse
  sequence s_read;
    reg_rd ##1 reg_rd_valid;
  endsequence
  chk_read_answer: assert property (reg_rd |-> s_read)
    else $error("read answer missing");
  chk_read_pulse: assert property (!reg_rd |=> !reg_rd_valid)
    else $error("read answer without read");
  chk_ramloc_high: assert property (reg_rd && reg_addr == 16'h841B |=> reg_rdata[7:1] == 7'h00)
    else $error("upper start address bits not zero");
  chk_hstart_back: assert property (reg_rd && reg_addr == 16'h8418 |=> reg_rdata == $past(hs_q))
    else $error("horizontal start readback wrong");
  chk_start_pixel: assert property ($rose(win2_pixel_on) |-> h_q == start_px + 11'h002)
    else $error("window started at wrong pixel");
  chk_flyback_stop: assert property (hflyback |-> ##2 !win2_pixel_on)
    else $error("window ran across flyback");
  chk_row_fetch: assert property (row_ctrl_valid |-> $past(ram_rd_en, 2))
    else $error("row code without fetch");
  chk_font_range: assert property (win2_pixel_on |-> win2_font_x <= 4'hB)
    else $error("font pixel beyond cell");
  chk_col_step: assert property (win2_pixel_on && $past(win2_pixel_on) && $past(win2_font_x) == 4'hB
    && win2_font_x == 4'h0 |-> win2_col == $past(win2_col) + 7'h01)
    else $error("column did not advance");
endmodule
`default_nettype wire

/* tb/osdw2_geometry_bench.sv */
// self-checking bench for the second osd window geometry block
`timescale 1ns/1ps
`default_nettype none
module osdw2_geometry_bench;
  logic        ref_clk = 1'b0;        // pixel clock
  logic        reset_n = 1'b0;        // held low at start
  logic        reg_wr = 1'b0;         // write strobe
  logic        reg_rd = 1'b0;         // read strobe
  logic [15:0] reg_addr = 16'h0000;   // byte address
  logic [7:0]  reg_wdata = 8'h00;     // write byte
  logic        win2_enable = 1'b1;    // window shown
  logic        hflyback = 1'b0;       // line start
  logic        vflyback = 1'b0;       // frame start
  logic        char_line_tick = 1'b0; // line done
  wire  [7:0]  reg_rdata;
  wire         reg_rd_valid;
  wire  [15:0] ram_rd_data;
  wire         ram_rd_en;
  wire  [8:0]  ram_rd_addr;
  wire  [15:0] row_control_code;
  wire         row_ctrl_valid;
  wire         win2_pixel_on;
  wire  [6:0]  win2_col;
  wire  [3:0]  win2_font_x;
  wire  [4:0]  win2_font_line;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;               // hang guard
  int          wid = 0;               // expected pixels per line
  logic [31:0] msk;                   // mask as written
  logic [10:0] px [0:511];            // column and font pixel per window pixel
  int          pi [0:7] = '{0, 1, 2, 3, 24, 25, 420, 421};
  logic [10:0] pe [0:7] = '{11'h000, 11'h000, 11'h001, 11'h001, 11'h010, 11'h011, 11'h200, 11'h201};
  logic [7:0]  wd [0:7] = '{8'h03, 8'h01, 8'h05, 8'h01, 8'h05, 8'h00, 8'h00, 8'h80};
  osdw2_geometry dut (
    .ref_clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
    .win2_enable, .hflyback, .vflyback, .char_line_tick,
    .win2_height_lines(10'h004), .win2_row_lines(5'h02), .win2_chars_per_row(7'h22),
    .ram_rd_data, .ram_rd_en, .ram_rd_addr, .row_control_code, .row_ctrl_valid,
    .win2_pixel_on, .win2_col, .win2_font_x, .win2_font_line
  );
  osdw2_page_ram ram (.ref_clk, .ram_rd_en, .ram_rd_addr, .ram_rd_data);
  always #5 ref_clk = ~ref_clk;
  // a hang counts as a mismatch and closes the run
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      stop_test;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // writes leave one idle edge so strobes never retrigger in one step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk("rd_valid", 1'b1, reg_rd_valid);
    chk("rdata", e, reg_rdata);
    @(negedge ref_clk);
  endtask
  // one scan line: flyback, watch outputs, then a character line tick
  task automatic scan(input logic on, input logic [8:0] base, input logic [10:0] st,
                      input logic [4:0] fl);
    int p = 0;
    int first = -1;
    int na = 0;
    logic [8:0] a0;
    logic [8:0] a1;
    logic [15:0] rc;
    logic [4:0] fl_seen;
    hflyback = 1'b1;
    @(negedge ref_clk);
    hflyback = 1'b0;
    for (int i = 0; i < 560; i++) begin
      if (ram_rd_en && na == 0) a0 = ram_rd_addr;
      if (ram_rd_en && na == 1) a1 = ram_rd_addr;
      if (ram_rd_en) na++;
      if (row_ctrl_valid) rc = row_control_code;
      if (win2_pixel_on && p == 0) begin
        first = i;
        fl_seen = win2_font_line;
      end
      if (win2_pixel_on && p < 512) px[p] = {win2_col, win2_font_x};
      if (win2_pixel_on) p++;
      char_line_tick = (i == 559);
      @(negedge ref_clk);
    end
    char_line_tick = 1'b0;
    chk("pixels", on ? wid : 0, p);
    if (on) begin
      chk("start", st + 2, first);
      chk("font_line", fl, fl_seen);
      chk("row_addr", base, a0);
      chk("row_code", {base[6:0] ^ 7'h55, base}, rc);
      chk("col0_addr", base + 9'h001, a1);
      for (int k = 0; k < 8; k++) chk("col_font", pe[k], px[pi[k]]);
    end
  endtask
  // frame of seven lines; window spans lines two to five but enable is low on five, so shown on two to four, row two at 0x128
  task automatic frame(input logic [7:0] hs);
    logic [10:0] st;
    st = ({3'b000, hs} << 2) + 11'h01E;
    if (st < 11'h02A) st = 11'h02A;
    wr(16'h8418, hs);
    vflyback = 1'b1;
    @(negedge ref_clk);
    vflyback = 1'b0;
    for (int l = 0; l < 7; l++) begin
      win2_enable = (l != 5);
      scan(l >= 2 && l <= 4, (l < 4) ? 9'h105 : 9'h128, st, (l == 3) ? 5'h01 : 5'h00);
    end
    win2_enable = 1'b1;
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    msk = {wd[7], wd[6], wd[5], wd[4]};
    for (int c = 0; c < 34; c++) wid += (c < 32 && msk[c]) ? 24 : 12;
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    for (int a = 0; a < 8; a++) rd(16'h8418 + 16'(a), 8'h00);
    rd(16'h8417, 8'h00);
    rd(16'h8420, 8'h00);
    for (int a = 0; a < 8; a++) wr(16'h8418 + 16'(a), wd[a]);
    for (int a = 0; a < 8; a++) rd(16'h8418 + 16'(a), (a == 3) ? 8'h01 : wd[a]);
    frame(8'h03);
    frame(8'h00);
    frame(8'h0A);
    stop_test;
  end
endmodule
bind osdw2_geometry osdw2_geometry_asserts chk_u (
  .ref_clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
  .hflyback, .ram_rd_en, .row_ctrl_valid, .win2_pixel_on, .win2_col, .win2_font_x
);
`default_nettype wire

/* tb/osdw2_page_ram.sv */
// page ram stand-in: one cycle answer, scrambled word otherwise
`timescale 1ns/1ps
`default_nettype none
module osdw2_page_ram (
  input  wire logic        ref_clk,
  input  wire logic        ram_rd_en,
  input  wire logic [8:0]  ram_rd_addr,
  output var  logic [15:0] ram_rd_data
);
  initial ram_rd_data = 16'hA5A5;
  // word encodes its address; stale word flips so a late capture shows
  always @(posedge ref_clk) begin
    if (ram_rd_en) ram_rd_data <= {ram_rd_addr[6:0] ^ 7'h55, ram_rd_addr};
    else ram_rd_data <= ~ram_rd_data;
  end
endmodule
`default_nettype wire
